/* inc/omac_defs.vh */
// omac_defs.vh: address map, register offsets, field positions and timing counts
// for the on-chip memory access controller; included by rtl/omac_top.v
`ifndef OMAC_DEFS_VH
`define OMAC_DEFS_VH
// memory map, 32-bit byte addresses
`define OMAC_ECC_LO        32'h20000000
`define OMAC_ECC_HI        32'h20007fff
`define OMAC_BANKA_LO      32'h20008000
`define OMAC_BANKA_HI      32'h2003ffff
`define OMAC_BANKB_LO      32'h20040000
`define OMAC_BANKB_HI      32'h2007ffff
`define OMAC_FAST_LO       32'h1ffe0000
`define OMAC_FAST_HI       32'h1fffffff
`define OMAC_STBY_LO       32'h200fe000
`define OMAC_STBY_HI       32'h200fffff
`define OMAC_FCMD_LO       32'h407e0000
`define OMAC_FCMD_HI       32'h407effff
`define OMAC_FCTL_LO       32'h407fc000
`define OMAC_FCTL_HI       32'h407fffff
`define OMAC_PFL_LO        32'h00000000
`define OMAC_PFL_HI        32'h001fffff
`define OMAC_DFL_LO        32'h08000000
`define OMAC_DFL_HI        32'h0800ffff
// control registers inside the flash control window (byte offsets from FCTL_LO)
`define OMAC_REG_CTRL      14'h0000
`define OMAC_REG_STAT      14'h0004
`define OMAC_REG_IDKEY0    14'h0010
// ctrl fields
`define OMAC_CTRL_RAMWAIT  0
`define OMAC_CTRL_PFWS_LSB 1
`define OMAC_CTRL_CUT_LSB  3
`define OMAC_CTRL_STOPA    5
`define OMAC_CTRL_STOPB    6
`define OMAC_CTRL_DEEPSBY  7
`define OMAC_CTRL_RESET    8'h01
// status fields
`define OMAC_STAT_PARERR   0
`define OMAC_STAT_ECCERR   1
`define OMAC_STAT_PROTERR  2
`define OMAC_STAT_DFLERR   3
`define OMAC_STAT_BUSY     4
`define OMAC_STAT_DBGOK    5
`define OMAC_STAT_STBYON   6
// flash commands written to the command area
`define OMAC_CMD_PF_PROG   8'he8
`define OMAC_CMD_PF_ERASE  8'h20
`define OMAC_CMD_DF_PROG   8'he9
`define OMAC_CMD_DF_ER64   8'h21
`define OMAC_CMD_DF_ER128  8'h22
`define OMAC_CMD_DF_ER256  8'h23
// timing: data flash read is seven flash clocks, flash clock 50 MHz from 200 MHz
`define OMAC_FLASH_INTERFACE_CLOCK_DIV      2'd3
`define OMAC_DFL_CYC       3'd7
`define OMAC_PF_UNIT       8'd128
`define OMAC_DF_UNIT       8'd2
`define OMAC_ERASE_CYC     12'd2000
`endif

/* rtl/omac_top.v */
// omac_top.v: on-chip memory access controller, bus slave over Avalon-MM
// assumes one clock core_clk, masters hold requests until waitrequest is low
//
// Functional notes
// - separate instruction and data ports share one address map, both served per cycle
// - ecc checking only on lowest 32 KB of bank a, parity elsewhere
// - decode bank a parity part and bank b address ranges
// - fast ram bank decoded, never any wait state
// - main ram reads take one wait state by default, software may remove
// - parity ram keeps one even parity bit per byte, made on write
// - ecc region keeps byte parity in the same field and detects one-bit errors per byte
// - main ram lost in deep standby, each bank has module stop
// - 8 KB standby ram decoded with byte even parity
// - standby ram powered in deep standby only when cut select is 00b
// - flash control space decoded as two windows
// - program flash read: hit one cycle, miss one to four by setting
// - data flash read takes seven flash interface clocks
// - erased program flash reads ffh, erased data flash undefined
// - flash program and erase started by commands written to command area
// - program flash 128-byte program, data flash 2-byte program, 64/128/256 erase
// - data flash refused while program flash busy, other memories readable
// - flash operations run in background, interrupts unaffected
// - 128-bit identifier all ones grants debug without check
// - programmed identifier refuses always or grants after matching key
// - protected region: read-write, write-blocked or fully blocked by constant
`timescale 1ns/1ps
`include "omac_defs.vh"
module omac_top #(
  parameter [127:0] ACCESS_ID   = {128{1'b1}}, // identifier in option area, all ones means open
  parameter         ID_LOCKED   = 1'b0,        // 1: refuse always when programmed
  parameter [31:0]  PROT_LO     = 32'h407ffffc,
  parameter [31:0]  PROT_HI     = 32'h407fffff,
  parameter [1:0]   PROT_MODE   = 2'd0         // 0 rw, 1 write blocked, 2 all blocked
) (
  // clock and reset
  input  wire        core_clk,
  input  wire        reset_n,
  // data port, Avalon-MM slave
  input  wire [31:0] avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [3:0]  avs_byteenable,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg  [1:0]  avs_response,
  output reg         avs_waitrequest,
  // instruction fetch port, read only Avalon-MM slave
  input  wire [31:0] ifp_address,
  input  wire        ifp_read,
  input  wire        ifp_cacheHit,
  output reg  [31:0] ifp_readdata,
  output reg  [1:0]  ifp_response,
  output reg         ifp_waitrequest,
  // debugger identifier check
  input  wire        dbgConnect,
  input  wire [127:0] dbgKey,
  output reg         dbgGranted,
  // power
  output reg         standbyRamPowered
);
  // memories: 16 words per region are modelled as flip-flops indexed by address bits
  localparam IDLE = 2'd0, WAIT = 2'd1, DONE = 2'd2, HOLD = 2'd3;
  reg  [35:0] ramMem [0:63];       // 4 regions x 16 words, 32 data + 4 parity
  reg  [31:0] pflMem [0:15];
  reg  [31:0] dflMem [0:15];
  reg  [7:0]  ctrl;
  reg  [3:0]  errFlags;
  reg  [1:0]  dState;
  reg  [1:0]  waitCnt;
  reg  [2:0]  dflCnt;
  reg  [1:0]  fclkDiv;
  reg  [1:0]  iState;
  reg  [1:0]  iCnt;
  reg         pfBusy;
  reg         dfBusy;
  reg  [11:0] busyCnt;
  reg         keyOk;
  reg         dbgSync1;
  reg         dbgSync2;
  reg  [127:0] keySync1;
  reg  [127:0] keySync2;
  reg  [1:0]  eraseKind;
  integer     k;

  // address range test used by every decoder
  function inRange;
    input [31:0] a;
    input [31:0] lo;
    input [31:0] hi;
    begin
      inRange = (a >= lo) && (a <= hi);
    end
  endfunction

  // even parity bit per byte
  function [3:0] byteParity;
    input [31:0] d;
    begin
      byteParity = {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]};
    end
  endfunction

  // data port region decode
  wire        hitEcc   = inRange(avs_address, `OMAC_ECC_LO, `OMAC_ECC_HI);
  wire        hitBankA = inRange(avs_address, `OMAC_BANKA_LO, `OMAC_BANKA_HI);
  wire        hitBankB = inRange(avs_address, `OMAC_BANKB_LO, `OMAC_BANKB_HI);
  wire        hitFast  = inRange(avs_address, `OMAC_FAST_LO, `OMAC_FAST_HI);
  wire        hitStby  = inRange(avs_address, `OMAC_STBY_LO, `OMAC_STBY_HI);
  wire        hitFcmd  = inRange(avs_address, `OMAC_FCMD_LO, `OMAC_FCMD_HI);
  wire        hitFctl  = inRange(avs_address, `OMAC_FCTL_LO, `OMAC_FCTL_HI);
  wire        hitPfl   = inRange(avs_address, `OMAC_PFL_LO, `OMAC_PFL_HI);
  wire        hitDfl   = inRange(avs_address, `OMAC_DFL_LO, `OMAC_DFL_HI);
  wire        hitProt  = inRange(avs_address, PROT_LO, PROT_HI);
  wire        hitRam   = hitEcc | hitBankA | hitBankB | hitFast | hitStby;
  wire        dReq     = avs_read | avs_write;
  wire [1:0]  ramSel   = hitEcc ? 2'd0 : hitFast ? 2'd3 : hitStby ? 2'd2 : 2'd1;
  wire        bankStop = (hitBankA & ctrl[`OMAC_CTRL_STOPA]) |
                         (hitBankB & ctrl[`OMAC_CTRL_STOPB]);
  wire        protBad  = hitProt & ((PROT_MODE == 2'd2) |
                         (PROT_MODE == 2'd1 & avs_write));
  wire        dflBad   = hitDfl & pfBusy;
  wire        mapBad   = ~(hitRam | hitFcmd | hitFctl | hitPfl | hitDfl);
  wire        isErr    = protBad | dflBad | mapBad | bankStop;
  wire [5:0]  ramIdx   = {ramSel, avs_address[5:2]};
  wire [35:0] ramWord  = ramMem[ramIdx];
  wire [13:0] regOff   = avs_address[13:0];
  wire        fclkTick = (fclkDiv == `OMAC_FLASH_INTERFACE_CLOCK_DIV);
  wire        idBlank  = (ACCESS_ID == {128{1'b1}});
  wire [7:0]  cmdCode  = avs_writedata[7:0];
  // commands act in the answer cycle of their write, once per write
  wire        cmdWrite = avs_write & hitFcmd & ~isErr;

  // ecc region: stored parity field checked per byte, a mismatch counts as an ecc error
  wire [3:0]  syndrome = byteParity(ramWord[31:0]) ^ ramWord[35:32];
  wire        eccHit   = (ramSel == 2'd0) & (|syndrome);
  wire        parHit   = (ramSel != 2'd0) & (|syndrome);

  // register read mux
  reg  [31:0] regRead;
  always @* begin
    regRead = 32'h00000000;
    if (regOff == `OMAC_REG_CTRL)
      regRead = {24'h000000, ctrl};
    else if (regOff == `OMAC_REG_STAT)
      regRead = {25'h0000000, standbyRamPowered, dbgGranted, pfBusy | dfBusy, errFlags};
  end

  // flash interface clock enable
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n)
      fclkDiv <= 2'd0;
    else
      fclkDiv <= fclkTick ? 2'd0 : fclkDiv + 2'd1;
  end

  // data port sequencer: IDLE decides wait, WAIT counts, DONE answers
  // HOLD lets the master drop its request before the next one is taken
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      dState          <= IDLE;
      waitCnt         <= 2'd0;
      dflCnt          <= 3'd0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
      avs_response    <= 2'b00;
    end else begin
      case (dState)
        IDLE: begin
          avs_waitrequest <= 1'b1;
          if (dReq) begin
            dState  <= WAIT;
            dflCnt  <= 3'd0;
            // only the ecc area and the two main banks take the read wait
            waitCnt <= (hitRam & ~hitFast & ~hitStby & avs_read & ctrl[`OMAC_CTRL_RAMWAIT]) ? 2'd1 : 2'd0;
          end
        end
        WAIT: begin
          if (hitDfl & ~isErr & avs_read) begin
            if (fclkTick)
              dflCnt <= dflCnt + 3'd1;
            if (dflCnt == `OMAC_DFL_CYC - 3'd1 && fclkTick)
              dState <= DONE;
          end else if (waitCnt != 2'd0) begin
            waitCnt <= waitCnt - 2'd1;
          end else begin
            dState <= DONE;
          end
        end
        DONE: begin
          avs_waitrequest <= 1'b0;
          avs_response    <= isErr ? 2'b10 : 2'b00;
          if (isErr)
            avs_readdata <= 32'h00000000;
          else if (hitRam)
            avs_readdata <= ramWord[31:0];
          else if (hitFctl)
            avs_readdata <= regRead;
          else if (hitPfl)
            avs_readdata <= pflMem[avs_address[5:2]];
          else if (hitDfl)
            avs_readdata <= dflMem[avs_address[5:2]];
          else
            avs_readdata <= 32'h00000000;
          dState <= HOLD;
        end
        // HOLD and any stray code: raise waitrequest again and go idle
        default: begin
          avs_waitrequest <= 1'b1;
          dState          <= IDLE;
        end
      endcase
    end
  end

  // instruction fetch port: parallel path into program flash only
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      iState          <= IDLE;
      iCnt            <= 2'd0;
      ifp_waitrequest <= 1'b1;
      ifp_readdata    <= 32'h00000000;
      ifp_response    <= 2'b00;
    end else begin
      case (iState)
        IDLE: begin
          ifp_waitrequest <= 1'b1;
          if (ifp_read) begin
            iState <= WAIT;
            iCnt   <= ifp_cacheHit ? 2'd0 : ctrl[`OMAC_CTRL_PFWS_LSB+1:`OMAC_CTRL_PFWS_LSB];
          end
        end
        WAIT: begin
          if (iCnt != 2'd0)
            iCnt <= iCnt - 2'd1;
          else
            iState <= DONE;
        end
        // answer stands one cycle, same shape as the data port
        DONE: begin
          ifp_waitrequest <= 1'b0;
          ifp_response    <= inRange(ifp_address, `OMAC_PFL_LO, `OMAC_PFL_HI) ? 2'b00 : 2'b10;
          ifp_readdata    <= pflMem[ifp_address[5:2]];
          iState          <= HOLD;
        end
        default: begin
          ifp_waitrequest <= 1'b1;
          iState          <= IDLE;
        end
      endcase
    end
  end

  // writes: ram with parity, control register, flash sequencer, error flags
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl      <= `OMAC_CTRL_RESET;
      errFlags  <= 4'h0;
      pfBusy    <= 1'b0;
      dfBusy    <= 1'b0;
      busyCnt   <= 12'd0;
      eraseKind <= 2'd0;
      for (k = 0; k < 64; k = k + 1)
        ramMem[k] <= 36'h000000000;
      for (k = 0; k < 16; k = k + 1) begin
        pflMem[k] <= 32'hffffffff;
        dflMem[k] <= 32'h00000000;
      end
    end else begin
      // ram write; ecc words keep check bits elsewhere, modelled in the same field
      if (dState == DONE && avs_write && hitRam && !isErr) begin
        for (k = 0; k < 4; k = k + 1)
          if (avs_byteenable[k]) begin
            ramMem[ramIdx][k*8 +: 8] <= avs_writedata[k*8 +: 8];
            ramMem[ramIdx][32+k]     <= ^avs_writedata[k*8 +: 8];
          end
      end
      // deep standby drops main ram and, unless kept, standby ram contents
      if (ctrl[`OMAC_CTRL_DEEPSBY]) begin
        for (k = 0; k < 32; k = k + 1)
          ramMem[k] <= 36'h000000000;
        if (ctrl[`OMAC_CTRL_CUT_LSB+1:`OMAC_CTRL_CUT_LSB] != 2'b00)
          for (k = 32; k < 48; k = k + 1)
            ramMem[k] <= 36'h000000000;
      end
      if (dState == DONE && avs_write && hitFctl && regOff == `OMAC_REG_CTRL)
        ctrl <= avs_writedata[7:0];
      // sticky error flags, set wins over write-one-to-clear
      if (dState == DONE && avs_write && hitFctl && regOff == `OMAC_REG_STAT)
        errFlags <= errFlags & ~avs_writedata[3:0];
      if (dState == DONE && avs_read && !isErr && parHit)
        errFlags[`OMAC_STAT_PARERR] <= 1'b1;
      if (dState == DONE && avs_read && !isErr && eccHit)
        errFlags[`OMAC_STAT_ECCERR] <= 1'b1;
      if (dState == DONE && protBad)
        errFlags[`OMAC_STAT_PROTERR] <= 1'b1;
      if (dState == DONE && dflBad)
        errFlags[`OMAC_STAT_DFLERR] <= 1'b1;
      // flash sequencer runs in background, bus stays live
      if (dState == DONE && cmdWrite && !pfBusy && !dfBusy) begin
        case (cmdCode)
          `OMAC_CMD_PF_PROG: begin
            pfBusy  <= 1'b1;
            busyCnt <= {4'h0, `OMAC_PF_UNIT};
            pflMem[avs_address[5:2]] <= 32'h00000000;
          end
          `OMAC_CMD_PF_ERASE: begin
            pfBusy    <= 1'b1;
            busyCnt   <= `OMAC_ERASE_CYC;
            eraseKind <= 2'd1;
          end
          `OMAC_CMD_DF_PROG: begin
            dfBusy  <= 1'b1;
            busyCnt <= {4'h0, `OMAC_DF_UNIT};
            dflMem[avs_address[5:2]][15:0] <= avs_writedata[31:16];
          end
          `OMAC_CMD_DF_ER64, `OMAC_CMD_DF_ER128, `OMAC_CMD_DF_ER256: begin
            dfBusy    <= 1'b1;
            busyCnt   <= {2'b00, cmdCode[1:0], 8'h40};
            eraseKind <= 2'd2;
          end
          default: ;
        endcase
      end else if (busyCnt != 12'd0) begin
        busyCnt <= busyCnt - 12'd1;
        if (busyCnt == 12'd1) begin
          pfBusy    <= 1'b0;
          dfBusy    <= 1'b0;
          eraseKind <= 2'd0;
          if (eraseKind == 2'd1)
            for (k = 0; k < 16; k = k + 1)
              pflMem[k] <= 32'hffffffff;
        end
      end
    end
  end

  // debugger identifier check, inputs from the tool pins are synchronised
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      dbgSync1          <= 1'b0;
      dbgSync2          <= 1'b0;
      keySync1          <= {128{1'b0}};
      keySync2          <= {128{1'b0}};
      keyOk             <= 1'b0;
      dbgGranted        <= 1'b0;
      standbyRamPowered <= 1'b1;
    end else begin
      dbgSync1 <= dbgConnect;
      dbgSync2 <= dbgSync1;
      keySync1 <= dbgKey;
      keySync2 <= keySync1;
      keyOk    <= (keySync2 == ACCESS_ID);
      if (idBlank)
        dbgGranted <= dbgSync2;
      else
        dbgGranted <= dbgSync2 & ~ID_LOCKED & keyOk;
      standbyRamPowered <= ~ctrl[`OMAC_CTRL_DEEPSBY] |
                           (ctrl[`OMAC_CTRL_CUT_LSB+1:`OMAC_CTRL_CUT_LSB] == 2'b00);
    end
  end
endmodule // omac_top

/* testbench/omac_bus_master.sv */
// omac_bus_master.sv: on-chip bus master model for the data and fetch ports
// assumes a slave that answers each held request by dropping waitrequest
`timescale 1ns/1ps
module omac_bus_master (
  // clock
  input  wire        core_clk,
  // data port
  output reg  [31:0] avs_address,
  output reg         avs_read,
  output reg         avs_write,
  output reg  [3:0]  avs_byteenable,
  output reg  [31:0] avs_writedata,
  input  wire [31:0] avs_readdata,
  input  wire [1:0]  avs_response,
  input  wire        avs_waitrequest,
  // fetch port
  output reg  [31:0] ifp_address,
  output reg         ifp_read,
  output reg         ifp_cacheHit,
  input  wire [31:0] ifp_readdata,
  input  wire [1:0]  ifp_response,
  input  wire        ifp_waitrequest,
  // an answer never came
  output reg         hung
);
  // idle lines at time zero
  initial begin
    {avs_address, avs_read, avs_write, avs_byteenable, avs_writedata} = 70'h0;
    {ifp_address, ifp_read, ifp_cacheHit, hung} = 35'h0;
  end

  // hold one request until waitrequest is sampled low, then release it
  task xfer(input f, input w, input h, input [31:0] a, input [31:0] d,
            output [31:0] q, output [1:0] r, output integer lat);
    integer n;
    begin
      @(posedge core_clk);
      if (f) begin
        ifp_address  <= {a[31:2], 2'b00}; // word aligned, never straddles two banks
        ifp_read     <= 1'b1;
        ifp_cacheHit <= h;
      end else begin
        avs_address    <= {a[31:2], 2'b00};
        avs_read       <= !w;
        avs_write      <= w; // flash commands go out as plain writes
        avs_byteenable <= 4'hf;
        avs_writedata  <= d;
      end
      lat = -1;
      for (n = 0; n < 100 && lat < 0; n = n + 1) begin
        @(posedge core_clk);
        if (!(f ? ifp_waitrequest : avs_waitrequest)) begin
          lat = n;
          q = f ? ifp_readdata : avs_readdata;
          r = f ? ifp_response : avs_response;
        end
      end
      hung <= lat < 0;
      {ifp_read, avs_read, avs_write} <= 3'b000;
      // released lines show no stale value
      avs_address   <= ~avs_address;
      avs_writedata <= ~avs_writedata;
      ifp_address   <= ~ifp_address;
    end
  endtask
endmodule // omac_bus_master

/* testbench/omac_checker_props.sv */
// omac_checker_props.sv: port-level checks of the memory access controller
// assumes masters release each request for a cycle after its answer
`timescale 1ns/1ps
`include "omac_defs.vh"
module omac_checker #(
  parameter [127:0] ACCESS_ID = {128{1'b1}}
) (
  // clock and reset
  input wire         core_clk,
  input wire         reset_n,
  // data port
  input wire [31:0]  avs_address,
  input wire         avs_read,
  input wire         avs_write,
  input wire [3:0]   avs_byteenable,
  input wire [31:0]  avs_writedata,
  input wire [31:0]  avs_readdata,
  input wire [1:0]   avs_response,
  input wire         avs_waitrequest,
  // fetch port
  input wire [31:0]  ifp_address,
  input wire         ifp_read,
  input wire         ifp_cacheHit,
  input wire [1:0]   ifp_response,
  input wire         ifp_waitrequest,
  // debug and power
  input wire         dbgConnect,
  input wire         dbgGranted,
  input wire         standbyRamPowered
);
  reg  [7:0] ctrlSeen; // last control byte written
  reg  [1:0] settle;   // cycles since that write, saturating
  wire       mainRam = avs_address >= `OMAC_ECC_LO && avs_address <= `OMAC_BANKB_HI && ctrlSeen[6:5] == 2'b00;
  wire       fastRam = avs_address >= `OMAC_FAST_LO && avs_address <= `OMAC_FAST_HI;
  wire       pfFetch = ifp_address <= `OMAC_PFL_HI;

  // follow control writes so wait and power settings are known
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrlSeen <= `OMAC_CTRL_RESET;
      settle   <= 2'd3;
    end else if (avs_write && !avs_waitrequest && avs_address == `OMAC_FCTL_LO && avs_byteenable[0]) begin
      ctrlSeen <= avs_writedata[7:0];
      settle   <= 2'd0;
    end else if (settle != 2'd3) begin
      settle <= settle + 2'd1;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // answer shapes counted from the edge that takes a request
  sequence ansPlain;
    avs_waitrequest [*3] ##1 !avs_waitrequest;
  endsequence
  sequence ansWait;
    avs_waitrequest [*4] ##1 !avs_waitrequest;
  endsequence

  wait_one_a: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  bus_idle_a: assert property (!avs_read && !avs_write |-> avs_waitrequest)
    else $error("waitrequest low without a request");
  fast_nowait_a: assert property ($rose(avs_read) && fastRam |-> ansPlain)
    else $error("fast bank read took a wait state");
  main_wait_a: assert property ($rose(avs_read) && mainRam && ctrlSeen[0] |-> ansWait)
    else $error("main bank read missed its wait state");
  main_nowait_a: assert property ($rose(avs_read) && mainRam && !ctrlSeen[0] |-> ansPlain)
    else $error("main bank read waited when disabled");
  unmapped_err_a: assert property (!avs_waitrequest && avs_read && avs_address[31:28] == 4'h3 |->
    avs_response == 2'b10 && avs_readdata == 32'h0) else $error("unmapped read not refused");
  fetch_hit_a: assert property ($rose(ifp_read) && ifp_cacheHit && pfFetch |->
    ifp_waitrequest [*3] ##1 !ifp_waitrequest) else $error("cache hit fetch too slow");
  fetch_miss_a: assert property ($rose(ifp_read) && !ifp_cacheHit && pfFetch && ctrlSeen[2:1] == 2'd2 |->
    ifp_waitrequest [*5] ##1 !ifp_waitrequest) else $error("cache miss fetch timing wrong");
  fetch_range_a: assert property (!ifp_waitrequest && ifp_read && !pfFetch |-> ifp_response == 2'b10)
    else $error("fetch outside program flash not refused");
  dbg_open_a: assert property (dbgConnect [*6] |-> ACCESS_ID != {128{1'b1}} || dbgGranted)
    else $error("blank identifier did not grant debug");
  stby_cut_a: assert property (settle == 2'd3 && ctrlSeen[7] && ctrlSeen[4:3] != 2'b00 |-> !standbyRamPowered)
    else $error("standby ram still powered after cut");
  stby_keep_a: assert property (settle == 2'd3 && ctrlSeen[4:3] == 2'b00 |-> standbyRamPowered)
    else $error("standby ram lost power");
endmodule // omac_checker

bind omac_top omac_checker #(.ACCESS_ID(ACCESS_ID)) omac_checker_i (.core_clk, .reset_n, .avs_address, .avs_read,
  .avs_write, .avs_byteenable, .avs_writedata, .avs_readdata, .avs_response, .avs_waitrequest, .ifp_address,
  .ifp_read, .ifp_cacheHit, .ifp_response, .ifp_waitrequest, .dbgConnect, .dbgGranted, .standbyRamPowered);

/* testbench/tb_onchip_memory_access_ctrl.sv */
// tb_onchip_memory_access_ctrl.sv: self-checking bench of the memory access controller
// assumes the bus master model and the checker are compiled first
`timescale 1ns/1ps
`include "omac_defs.vh"
module tb_onchip_memory_access_ctrl;
  localparam [31:0]  CT    = `OMAC_FCTL_LO;
  localparam [31:0]  ST    = `OMAC_FCTL_LO + 32'h4;
  localparam [159:0] BASES = {`OMAC_ECC_LO, `OMAC_BANKA_LO, `OMAC_BANKB_LO, `OMAC_FAST_LO, `OMAC_STBY_LO};
  localparam [39:0]  CMDS  = {`OMAC_CMD_DF_PROG, `OMAC_CMD_DF_ER64, `OMAC_CMD_DF_ER128, `OMAC_CMD_DF_ER256,
                              `OMAC_CMD_PF_PROG};
  reg         core_clk;
  reg         reset_n;
  reg         dbgConnect;
  reg [127:0] dbgKey;
  reg [31:0]  seed, q, a, d;
  reg [1:0]   r;
  integer     lat, i, mismatches, n_checks;
  wire [31:0] avs_address, avs_writedata, avs_readdata, ifp_address, ifp_readdata;
  wire [3:0]  avs_byteenable;
  wire [1:0]  avs_response, ifp_response;
  wire        avs_read, avs_write, avs_waitrequest, ifp_read, ifp_cacheHit, ifp_waitrequest;
  wire        dbgGranted, standbyRamPowered, hung;

  omac_top #(.PROT_LO(32'h2007fffc), .PROT_HI(32'h2007ffff), .PROT_MODE(2'd1)) omac_top_i (.core_clk, .reset_n,
    .avs_address, .avs_read, .avs_write, .avs_byteenable, .avs_writedata, .avs_readdata, .avs_response,
    .avs_waitrequest, .ifp_address, .ifp_read, .ifp_cacheHit, .ifp_readdata, .ifp_response, .ifp_waitrequest,
    .dbgConnect, .dbgKey, .dbgGranted, .standbyRamPowered);
  omac_bus_master omac_bus_master_i (.core_clk, .avs_address, .avs_read, .avs_write, .avs_byteenable,
    .avs_writedata, .avs_readdata, .avs_response, .avs_waitrequest, .ifp_address, .ifp_read, .ifp_cacheHit,
    .ifp_readdata, .ifp_response, .ifp_waitrequest, .hung);

  // main banks take one more cycle while the wait bit is set
  function integer expLat(input [31:0] x, input c);
    expLat = (x >= `OMAC_ECC_LO && x <= `OMAC_BANKB_HI && c) ? 4 : 3;
  endfunction

  task chk(input string what, input [31:0] exp, input [31:0] got);
    begin
      n_checks = n_checks + 1;
      if (exp !== got) begin
        mismatches = mismatches + 1;
        $display("wrong value %s expected %h seen %h", what, exp, got);
      end
    end
  endtask

  task acc(input w, input [31:0] x, input [31:0] v);
    omac_bus_master_i.xfer(1'b0, w, 1'b0, x, v, q, r, lat);
  endtask

  task ftc(input [31:0] x, input h);
    omac_bus_master_i.xfer(1'b1, 1'b0, h, x, 32'h0, q, r, lat);
  endtask

  // poll the busy flag until the flash sequencer is done
  task idle;
    integer k;
    begin
      q = 32'h10;
      for (k = 0; k < 1000 && q[4]; k = k + 1) acc(1'b0, ST, 32'h0);
      if (q[4]) begin
        mismatches = mismatches + 1;
        summarize;
      end
    end
  endtask

  task summarize;
    begin
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // a wait that ran out ends the run
  always @(posedge hung) begin
    mismatches = mismatches + 1;
    summarize;
  end

  initial begin
    seed = 32'h0e6f;
    {mismatches, n_checks, reset_n, dbgConnect, dbgKey} = 0;
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    chk("power at reset", 1, standbyRamPowered);
    acc(1'b0, CT, 32'h0);
    chk("ctrl reset", `OMAC_CTRL_RESET, q[7:0]);
    // random words through every ram region
    for (i = 0; i < 15; i = i + 1) begin
      a = BASES[(i % 5) * 32 +: 32] + {$random(seed)} % 16 * 4;
      d = $random(seed);
      acc(1'b1, a, d);
      chk("ram write resp", 0, r);
      acc(1'b0, a, 32'h0);
      chk("ram read", d, q);
      chk("ram latency", expLat(a, 1'b1), lat);
    end
    acc(1'b1, CT, 32'h0);
    acc(1'b0, `OMAC_BANKB_LO, 32'h0);
    chk("no wait latency", expLat(`OMAC_BANKB_LO, 1'b0), lat);
    $display("test ram done");
    acc(1'b0, 32'h30000000, 32'h0);
    chk("unmapped resp", 2, r);
    chk("unmapped data", 0, q);
    acc(1'b1, 32'h2007fffc, $random(seed));
    chk("blocked write", 2, r);
    acc(1'b0, 32'h2007fffc, 32'h0);
    chk("allowed read", 0, r);
    acc(1'b0, ST, 32'h0);
    chk("protect flag", 1, q[`OMAC_STAT_PROTERR]);
    acc(1'b1, ST, 32'hf);
    acc(1'b0, ST, 32'h0);
    chk("flags cleared", 0, q[3:0]);
    acc(1'b1, CT, 32'h21);
    acc(1'b0, `OMAC_BANKA_LO, 32'h0);
    chk("stopped bank", 2, r);
    $display("test refuse done");
    acc(1'b1, CT, 32'h89);
    acc(1'b0, ST, 32'h0);
    chk("power cut", 0, standbyRamPowered);
    acc(1'b1, CT, 32'h81);
    acc(1'b0, ST, 32'h0);
    chk("power kept", 1, standbyRamPowered);
    $display("test standby done");
    for (i = 0; i < 4; i = i + 1) begin
      acc(1'b1, CT, i * 2 + 1);
      a = $random(seed) & 32'h3c;
      ftc(a, 1'b0);
      chk("miss latency", 3 + i, lat);
      ftc(a, 1'b1);
      chk("hit latency", 3, lat);
      chk("fetch data", 32'hffffffff, q);
    end
    ftc(`OMAC_ECC_LO, 1'b1);
    chk("fetch range", 2, r);
    acc(1'b1, CT, 32'h01);
    $display("test fetch done");
    acc(1'b0, `OMAC_DFL_LO, 32'h0);
    chk("dflash latency", 1, lat >= 27 && lat <= 33);
    for (i = 0; i < 5; i = i + 1) begin
      acc(1'b1, `OMAC_FCMD_LO, CMDS[i * 8 +: 8]);
      chk("command resp", 0, r);
      idle;
    end
    acc(1'b1, `OMAC_FCMD_LO, `OMAC_CMD_PF_ERASE);
    acc(1'b0, ST, 32'h0);
    chk("busy", 1, q[`OMAC_STAT_BUSY]);
    acc(1'b0, `OMAC_DFL_LO, 32'h0);
    chk("dflash refused", 2, r);
    acc(1'b0, `OMAC_ECC_LO, 32'h0);
    chk("ram while busy", 0, r);
    acc(1'b0, ST, 32'h0);
    chk("refuse flag", 1, q[`OMAC_STAT_DFLERR]);
    idle;
    acc(1'b0, `OMAC_PFL_LO, 32'h0);
    chk("erased word", 32'hffffffff, q);
    $display("test flash done");
    dbgKey <= {$random(seed), $random(seed), $random(seed), $random(seed)};
    dbgConnect <= 1'b1;
    for (i = 0; i < 20 && dbgGranted !== 1'b1; i = i + 1) @(posedge core_clk);
    chk("debug grant", 1, dbgGranted);
    $display("test debug done");
    summarize;
  end
endmodule // tb_onchip_memory_access_ctrl
